/* design/etsc_top.v */
// envelope trigger detection and stage sequencing for one voice
// What this block does
// R1: falling polarity fires when a decreasing source reaches the threshold
// R2: either-way polarity fires when the source reaches threshold in any direction
// R3: rising polarity fires when an increasing source reaches the threshold
// R4: magnitude falling fires on decreasing source reaching threshold magnitude
// R5: magnitude either-way fires on source reaching threshold magnitude either way
// R6: magnitude rising fires on increasing source reaching threshold magnitude
// R7: behaviour setting has seven values governing stage progression; here every code runs the first normal mode
// R8: envelope emits a trigger event when attack output reaches a set level
// R9: note events from every source are treated the same
// R10: pedal hold is true only when enabled and pedal pressed
// R11: first normal mode starts its cycle on note-on
// R12: held note walks delay, attack, decay one, decay two, then sustain
// R13: sustain holds while note or pedal hold; both gone enters release one
// R14: note ended early then pedal hold jumps to sustain at current level
// R15: note-off in sustain without pedal hold enters release one
// R16: early note-off without pedal hold jumps to release one from present level
// R17: a new note-on during release restarts from the present output level
// R18: trigger input is one-shot; ignored until the envelope stops
// R19: threshold is signed, minus to plus one hundred; trigger enable gates it
// R20: direction from previous sample; crossing when threshold between or equal
// R21: cycle ends and becomes idle when release two reaches zero output
`default_nettype none
`include "etsc_map.vh"
module etsc_top (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire kbd_note_on,
  input wire kbd_note_off,
  input wire seq_note_on,
  input wire seq_note_off,
  input wire arp_note_on,
  input wire arp_note_off,
  input wire midi_note_on,
  input wire midi_note_off,
  input wire pedal_down,
  input wire pedal_hold_enable,
  input wire trigger_enable,
  input wire src_valid,
  input wire [7:0] src_sample,
  input wire [7:0] threshold,
  input wire [2:0] polarity,
  input wire [2:0] behaviour,
  input wire [7:0] env_level,
  input wire stage_done,
  input wire [7:0] attack_hit_level,
  output reg [2:0] stage_q,
  output reg restart_q,
  output reg hold_level_q,
  output reg note_held_q,
  output wire pedal_hold,
  output wire trig_fire,
  output wire attack_hit,
  output wire env_active
);
  ////////////////////////////////////////////////////////////////
  // note and hold qualifiers
  wire note_on_any;
  wire note_off_any;
  wire det_fire;
  reg note_d;
  reg [2:0] stage_d;
  reg restart_d;
  reg hold_d;
  reg early_off_q;
  reg early_off_d;
  wire hold_any;

  // every note source merges into one on/off pair
  assign note_on_any = kbd_note_on | seq_note_on | arp_note_on | midi_note_on; // see R9
  assign note_off_any = kbd_note_off | seq_note_off | arp_note_off | midi_note_off; // see R9
  assign pedal_hold = pedal_hold_enable & pedal_down; // see R10
  assign env_active = (stage_q != `ETSC_ST_IDLE);
  // one-shot: triggers only pass while the envelope is stopped
  assign trig_fire = det_fire & trigger_enable & ~env_active; // see R18 R19

  always @* begin
    note_d = note_held_q;
    if (note_off_any)
      note_d = 1'b0;
    if (note_on_any)
      note_d = 1'b1;
  end

  assign hold_any = note_d | pedal_hold;

  ////////////////////////////////////////////////////////////////
  // detector and attack-level event
  etsc_cross_det u_det (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .src_valid(src_valid),
    .src_sample(src_sample),
    .threshold(threshold),
    .polarity(polarity),
    .fire_q(det_fire)
  );

  etsc_level_hit u_hit (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .in_attack(stage_q == `ETSC_ST_ATTACK),
    .env_level(env_level),
    .hit_level(attack_hit_level),
    .hit_q(attack_hit)
  );

  ////////////////////////////////////////////////////////////////
  // stage sequencer; only the first normal mode is sequenced here,
  // other behaviour codes fall back to it so the voice never hangs
  always @* begin
    stage_d = stage_q;
    restart_d = 1'b0;
    hold_d = 1'b0;
    early_off_d = early_off_q;
    case (behaviour) // see R7
      default: begin
        if (note_on_any || trig_fire) begin
          // restart is from the present output, the stage engine keeps its level
          if (!env_active || stage_q == `ETSC_ST_RELEASE1 ||
              stage_q == `ETSC_ST_RELEASE2 || note_on_any) begin
            stage_d = `ETSC_ST_DELAY; // see R11 R17
            restart_d = 1'b1; // see R17
            early_off_d = 1'b0;
          end
        end else begin
          case (stage_q)
            `ETSC_ST_IDLE: stage_d = `ETSC_ST_IDLE;
            `ETSC_ST_DELAY, `ETSC_ST_ATTACK, `ETSC_ST_DECAY1, `ETSC_ST_DECAY2: begin
              if (!note_d && !pedal_hold) begin
                // remember the early end so a later pedal can still catch the level
                stage_d = `ETSC_ST_RELEASE1; // see R16
                early_off_d = 1'b1;
              end else if (!note_d) begin
                stage_d = `ETSC_ST_SUSTAIN; // see R14
                hold_d = 1'b1; // see R14
                early_off_d = 1'b1;
              end else if (stage_done) begin
                stage_d = stage_q + 3'h1; // see R12
              end
            end
            `ETSC_ST_SUSTAIN: begin
              hold_d = early_off_q & hold_any; // see R14
              if (!hold_any) begin
                stage_d = `ETSC_ST_RELEASE1; // see R13 R15
                early_off_d = 1'b0;
              end
            end
            `ETSC_ST_RELEASE1: begin
              if (early_off_q && pedal_hold) begin
                stage_d = `ETSC_ST_SUSTAIN; // see R14
                hold_d = 1'b1; // see R14
              end else if (stage_done) begin
                stage_d = `ETSC_ST_RELEASE2; // see R16
              end
            end
            `ETSC_ST_RELEASE2: begin
              if (stage_done && env_level == 8'h00) begin
                stage_d = `ETSC_ST_IDLE; // see R21
                early_off_d = 1'b0;
              end
            end
            default: stage_d = `ETSC_ST_IDLE;
          endcase
        end
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_q <= `ETSC_RST_STAGE;
      restart_q <= 1'b0;
      hold_level_q <= 1'b0;
      note_held_q <= 1'b0;
      early_off_q <= 1'b0;
    end else if (ce) begin
      stage_q <= stage_d;
      restart_q <= restart_d;
      hold_level_q <= hold_d;
      note_held_q <= note_d;
      early_off_q <= early_off_d;
    end
  end
endmodule
`default_nettype wire

/* design/etsc_map.vh */
// constants for the envelope trigger and stage controller
`ifndef ETSC_MAP_VH
`define ETSC_MAP_VH
// trigger polarity codes
`define ETSC_POL_FALLING 3'h0
`define ETSC_POL_EITHER 3'h1
`define ETSC_POL_RISING 3'h2
`define ETSC_POL_MAG_FALLING 3'h3
`define ETSC_POL_MAG_EITHER 3'h4
`define ETSC_POL_MAG_RISING 3'h5
// envelope behaviour codes
`define ETSC_MODE_NORMAL_FIRST 3'h0
`define ETSC_MODE_NORMAL_SECOND 3'h1
`define ETSC_MODE_FREE_RUNNING 3'h2
`define ETSC_MODE_FREE_RUNNING_HOLD 3'h3
`define ETSC_MODE_HOLD_RELEASE_MERGE 3'h4
`define ETSC_MODE_MODULATION_START 3'h5
`define ETSC_MODE_MODULATION_START_GATED 3'h6
// stage codes
`define ETSC_ST_IDLE 3'h0
`define ETSC_ST_DELAY 3'h1
`define ETSC_ST_ATTACK 3'h2
`define ETSC_ST_DECAY1 3'h3
`define ETSC_ST_DECAY2 3'h4
`define ETSC_ST_SUSTAIN 3'h5
`define ETSC_ST_RELEASE1 3'h6
`define ETSC_ST_RELEASE2 3'h7
// threshold limits, signed 8 bit
`define ETSC_LEVEL_MAX 8'h64
`define ETSC_LEVEL_MIN 8'h9C
// reset values
`define ETSC_RST_LEVEL 8'h00
`define ETSC_RST_STAGE 3'h0
`endif

/* design/etsc_cross_det.v */
// level-crossing trigger detector on a signed source
`default_nettype none
`include "etsc_map.vh"
module etsc_cross_det (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire src_valid,
  input wire signed [7:0] src_sample,
  input wire signed [7:0] threshold,
  input wire [2:0] polarity,
  output reg fire_q
);
  reg signed [7:0] prev_q;
  reg have_prev_q;
  reg signed [7:0] thr_clip;
  reg signed [7:0] thr_eff;
  reg rising;
  reg falling;
  reg between;
  reg fire_d;

  always @* begin
    // clamp to the legal range so abs never overflows
    thr_clip = threshold;
    if (threshold > $signed(`ETSC_LEVEL_MAX))
      thr_clip = `ETSC_LEVEL_MAX; // see R19
    if (threshold < $signed(`ETSC_LEVEL_MIN))
      thr_clip = `ETSC_LEVEL_MIN; // see R19
    thr_eff = thr_clip;
    if ((polarity == `ETSC_POL_MAG_FALLING || polarity == `ETSC_POL_MAG_EITHER ||
         polarity == `ETSC_POL_MAG_RISING) && thr_clip[7])
      thr_eff = -thr_clip; // see R4 R5 R6
    rising = src_sample > prev_q; // see R20
    falling = src_sample < prev_q; // see R20
    between = (src_sample == thr_eff) ||
              (rising && prev_q < thr_eff && src_sample > thr_eff) ||
              (falling && prev_q > thr_eff && src_sample < thr_eff); // see R20
    fire_d = 1'b0;
    if (src_valid && have_prev_q && between) begin
      case (polarity)
        `ETSC_POL_FALLING: fire_d = falling; // see R1
        `ETSC_POL_EITHER: fire_d = rising | falling; // see R2
        `ETSC_POL_RISING: fire_d = rising; // see R3
        `ETSC_POL_MAG_FALLING: fire_d = falling; // see R4
        `ETSC_POL_MAG_EITHER: fire_d = rising | falling; // see R5
        `ETSC_POL_MAG_RISING: fire_d = rising; // see R6
        default: fire_d = 1'b0;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_q <= `ETSC_RST_LEVEL;
      have_prev_q <= 1'b0;
      fire_q <= 1'b0;
    end else if (ce) begin
      fire_q <= fire_d;
      if (src_valid) begin
        prev_q <= src_sample;
        have_prev_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* design/etsc_level_hit.v */
// one-shot event when the attack output reaches a set level
`default_nettype none
`include "etsc_map.vh"
module etsc_level_hit (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire in_attack,
  input wire [7:0] env_level,
  input wire [7:0] hit_level,
  output reg hit_q
);
  reg armed_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (ce) begin
      hit_q <= 1'b0;
      if (!in_attack) begin
        armed_q <= 1'b1;
      end else if (armed_q && env_level >= hit_level) begin
        hit_q <= 1'b1; // see R8
        armed_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/etsc_note_src.sv */
// note sources and sustain pedal that feed the envelope controller
`default_nettype none
module etsc_note_src (
  input wire logic clk_sys,
  output var logic [3:0] on_p,
  output var logic [3:0] off_p,
  output var logic pedal_down
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    on_p = 4'h0;
    off_p = 4'h0;
    pedal_down = 1'b0;
  end
  // one-cycle pulse from any source; an on and an off never share a cycle
  task automatic send(input int s, input logic on);
    @(posedge clk_sys);
    on_p[s] <= on;
    off_p[s] <= !on;
    @(posedge clk_sys);
    on_p <= 4'h0;
    off_p <= 4'h0;
  endtask
  task automatic pedal(input logic v);
    @(posedge clk_sys);
    pedal_down <= v;
  endtask
endmodule
`default_nettype wire

/* verif/etsc_top_monitor.sv */
// concurrent checks on the stage controller ports
`default_nettype none
module etsc_top_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] on_v,
  input wire logic [3:0] off_v,
  input wire logic pedal_hold,
  input wire logic trigger_enable,
  input wire logic [7:0] env_level,
  input wire logic stage_done,
  input wire logic [2:0] stage_q,
  input wire logic note_held_q,
  input wire logic hold_level_q,
  input wire logic restart_q,
  input wire logic trig_fire,
  input wire logic attack_hit,
  input wire logic env_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic on_any = |on_v;
  wire logic off_any = (|off_v) & !on_any;
  sequence s_early_off;
    ce && off_any && !pedal_hold && stage_q inside {[3'h1:3'h4]};
  endsequence
  sequence s_last;
    ce && !on_any && stage_q == 3'h7 && stage_done && env_level == 8'h00;
  endsequence
  a_note_start: assert property (ce && on_any |=> stage_q == 3'h1 && restart_q)
    else $error("note-on did not restart the cycle");
  a_stage_walk: assert property (ce && note_held_q && !on_any && !(|off_v) && stage_done
    && stage_q inside {[3'h1:3'h4]} |=> stage_q == $past(stage_q) + 3'h1)
    else $error("held note did not advance one stage");
  a_sus_release: assert property (ce && off_any && !pedal_hold && stage_q == 3'h5
    |=> stage_q == 3'h6) else $error("note-off in sustain missed release one");
  a_early_jump: assert property (s_early_off |=> stage_q == 3'h6)
    else $error("early note-off missed release one");
  a_end_idle: assert property (s_last |=> stage_q == 3'h0 && !env_active)
    else $error("release two at zero did not go idle");
  a_trig_gate: assert property (trig_fire |-> trigger_enable && !env_active)
    else $error("trigger fired while masked");
  a_trig_start: assert property (ce && trig_fire && !on_any |=> stage_q == 3'h1)
    else $error("trigger did not start the cycle");
  a_hit_attack: assert property (attack_hit |-> $past(stage_q) == 3'h2 ##1 !attack_hit)
    else $error("attack hit outside attack or held");
  a_hold_stage: assert property (hold_level_q |-> stage_q == 3'h5)
    else $error("level hold outside sustain");
endmodule
bind etsc_top etsc_top_monitor etsc_top_monitor_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .on_v({midi_note_on, arp_note_on, seq_note_on, kbd_note_on}),
  .off_v({midi_note_off, arp_note_off, seq_note_off, kbd_note_off}),
  .pedal_hold(pedal_hold), .trigger_enable(trigger_enable), .env_level(env_level),
  .stage_done(stage_done), .stage_q(stage_q), .note_held_q(note_held_q),
  .hold_level_q(hold_level_q), .restart_q(restart_q),
  .trig_fire(trig_fire), .attack_hit(attack_hit), .env_active(env_active));
`default_nettype wire

/* verif/etsc_top_tb_top.sv */
// self-checking bench for the envelope trigger and stage controller
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module etsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, stage_done = 1'b0, pedal_hold_enable = 1'b0;
  logic trigger_enable = 1'b0, ce = 1'b1, src_valid = 1'b1;
  logic [7:0] src_sample = 8'h00, threshold = 8'h00, env_level = 8'h40, hit_level = 8'h20;
  logic [2:0] polarity = 3'h0, behaviour = 3'h0, seen_q = 3'h0, exp_now;
  logic [2:0] exp_q[$];
  logic [31:0] lfsr = 32'hF1EA10C7;
  int n_fail = 0, check_count = 0, n_hit = 0;
  wire logic [3:0] on_p, off_p;
  wire logic pedal_down, pedal_hold, hold_level_q, restart_q, note_held_q;
  wire logic trig_fire, attack_hit, env_active;
  wire logic [2:0] stage_q;
  always #5 clk_sys = ~clk_sys;
  etsc_note_src etsc_note_src_i (.clk_sys(clk_sys), .on_p(on_p), .off_p(off_p),
    .pedal_down(pedal_down));
  etsc_top etsc_top_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .kbd_note_on(on_p[0]), .kbd_note_off(off_p[0]), .seq_note_on(on_p[1]),
    .seq_note_off(off_p[1]), .arp_note_on(on_p[2]), .arp_note_off(off_p[2]),
    .midi_note_on(on_p[3]), .midi_note_off(off_p[3]), .pedal_down(pedal_down),
    .pedal_hold_enable(pedal_hold_enable), .trigger_enable(trigger_enable),
    .src_valid(src_valid), .src_sample(src_sample), .threshold(threshold), .polarity(polarity),
    .behaviour(behaviour), .env_level(env_level), .stage_done(stage_done),
    .attack_hit_level(hit_level), .stage_q(stage_q), .restart_q(restart_q),
    .hold_level_q(hold_level_q), .note_held_q(note_held_q), .pedal_hold(pedal_hold),
    .trig_fire(trig_fire), .attack_hit(attack_hit), .env_active(env_active));
  ////////////////////////////////////////////////////////////////////////////////////
  function automatic [31:0] lfsr_next(input [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic step(logic [2:0] nxt);
    exp_q.push_back(nxt);
    @(posedge clk_sys);
    stage_done <= 1'b1;
    @(posedge clk_sys);
    stage_done <= 1'b0;
  endtask
  // a negative nxt means the stage must not move
  task automatic note(int s, logic on, int nxt);
    if (nxt >= 0)
      exp_q.push_back(nxt[2:0]);
    etsc_note_src_i.send(s, on);
  endtask
  task automatic to_idle;
    step(3'h7);
    env_level <= 8'h00;
    step(3'h0);
    env_level <= 8'h40;
  endtask
  // source jumps across the threshold in one sample, endpoints random
  task automatic sweep(logic [2:0] pol, logic up, logic idle);
    logic [7:0] a;
    lfsr = lfsr_next(lfsr);
    a = 8'h1E + {2'h0, lfsr[5:0]} % 8'h28;
    trigger_enable <= 1'b0;
    polarity <= pol;
    threshold <= (pol > 3'h2) ? 8'hEC : 8'h14;
    src_sample <= up ? -a : a;
    src_valid <= lfsr[6];
    tick(1);
    src_valid <= 1'b1;
    tick(2);
    trigger_enable <= 1'b1;
    src_sample <= up ? a : -a;
    if (idle && (up ? pol % 3 != 0 : pol % 3 != 2)) begin
      // no note is held after a trigger start, so the core drops straight to release one
      exp_q.push_back(3'h1);
      exp_q.push_back(3'h6);
      tick(6);
      note(0, 1'b0, -1);
      to_idle();
    end else
      tick(6);
    trigger_enable <= 1'b0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (!rst && stage_q !== seen_q) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        check_count++;
        $display("wrong value at %0t: stage moved to %h unexpectedly", $time, stage_q);
      end else begin
        exp_now = exp_q.pop_front();
        `CHK(stage_q, exp_now)
      end
      seen_q = stage_q;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst && attack_hit === 1'b1)
      n_hit++;
  end
  initial begin
    tick(20000);
    n_fail++;
    $display("wrong value at %0t: run timed out", $time);
    finish_test();
  end
  initial begin
    tick(12);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      behaviour <= k[2:0];
      pedal_hold_enable <= k[0];
      // above the engine level in the second pair, so no attack event there
      hit_level <= {k[1], 7'h20};
      note(k, 1'b1, 1);
      for (int s = 2; s < 6; s++)
        step(s[2:0]);
      etsc_note_src_i.pedal(1'b1);
      tick(1);
      `CHK(pedal_hold, k[0])
      note(k, 1'b0, k[0] ? -1 : 6);
      tick(3);
      if (k[0])
        exp_q.push_back(3'h6);
      etsc_note_src_i.pedal(1'b0);
      to_idle();
    end
    note(3, 1'b1, 1);
    // a frozen core must lose this stage_done pulse
    ce <= 1'b0;
    tick(1);
    stage_done <= 1'b1;
    tick(1);
    stage_done <= 1'b0;
    ce <= 1'b1;
    `CHK(note_held_q, 1'b1)
    step(3'h2);
    note(3, 1'b0, 6);
    exp_q.push_back(3'h5);
    etsc_note_src_i.pedal(1'b1);
    tick(2);
    `CHK(hold_level_q, 1'b1)
    exp_q.push_back(3'h6);
    etsc_note_src_i.pedal(1'b0);
    note(1, 1'b1, 1);
    sweep(3'h1, 1'b1, 1'b0);
    note(1, 1'b0, 6);
    to_idle();
    for (int p = 0; p < 6; p++)
      for (int u = 0; u < 2; u++)
        sweep(p[2:0], u[0], 1'b1);
    tick(3);
    `CHK(exp_q.size(), 0)
    `CHK(n_hit, 2)
    finish_test();
  end
endmodule
`default_nettype wire
